/* bench/asc_properties.sv */
// Port checks of the converter control block
`timescale 1ns/1ns
`default_nettype none
module asc_properties (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire asc_pkg::asc_apb_req_s apb_req,
    input wire asc_pkg::asc_apb_rsp_s apb_rsp,
    input wire logic [11:0] core_result,
    input wire logic [9:0] pin_analog_assign,
    input wire asc_pkg::asc_analog_s analog,
    input wire logic converter_irq
);
    import asc_pkg::*;
    logic acc;
    logic ctrl_wr;
    logic start_q;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    // ==========
    // Access and control write decode
    assign acc = apb_req.psel && apb_req.penable;
    assign ctrl_wr = acc && apb_rsp.pready && apb_req.pwrite && apb_req.paddr == 12'h000;
    // Start bit as last written
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            start_q <= 1'b0;
        end else if (ctrl_wr) begin
            start_q <= apb_req.pwdata[7];
        end
    end
    sequence s_start;
        ctrl_wr && start_q && !apb_req.pwdata[7];
    endsequence
    sequence s_idle;
        analog.power_en && !analog.sample && !analog.convert
            && !$past(analog.convert) && !$past(analog.convert, 2);
    endsequence
    // ==========
    // Assertions
    a_ready_one_wait:
    assert property (acc && !apb_rsp.pready |=> apb_rsp.pready) else $error("pready late");
    a_ready_one_cycle:
    assert property (apb_rsp.pready |=> !apb_rsp.pready) else $error("pready held");
    a_unmapped_error:
    assert property (acc && apb_rsp.pready && apb_req.paddr > 12'h014
        |-> apb_rsp.pslverr && apb_rsp.prdata == 32'h0) else $error("unmapped");
    a_upper_zero:
    assert property (apb_rsp.pready |-> apb_rsp.prdata[31:8] == 24'h0) else $error("upper");
    a_ref_pin_off:
    assert property (analog.ref_sel == REF_INTERNAL |-> !analog.ref_pin_connect)
        else $error("ref pin");
    a_internal_ext_off:
    assert property (analog.src != SRC_EXTERNAL |-> !analog.ext_connect) else $error("ext path");
    a_pins_follow:
    assert property (analog.digital_off == $past(pin_analog_assign)
        && analog.pullhigh_off == $past(pin_analog_assign)) else $error("pin release");
    a_power_follows:
    assert property (ctrl_wr |=> ##1 analog.power_en == $past(apb_req.pwdata[5], 2))
        else $error("power");
    a_start_begins:
    assert property (s_start ##0 s_idle |=> analog.sample) else $error("no start");
    a_start_ignored:
    assert property (ctrl_wr && !analog.power_en && !analog.sample && !analog.convert
        |=> !analog.sample) else $error("start off");
    a_sample_convert:
    assert property ($fell(analog.sample) && analog.power_en && !$past(ctrl_wr)
        |-> analog.convert) else $error("phase order");
endmodule : asc_properties
bind asc_top asc_properties chk_u (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .apb_req(apb_req),
    .apb_rsp(apb_rsp),
    .core_result(core_result),
    .pin_analog_assign(pin_analog_assign),
    .analog(analog),
    .converter_irq(converter_irq)
);
`default_nettype wire

/* bench/tb_adc_sequencer_control.sv */
// Self-checking bench of the converter control block
`timescale 1ns/1ns
`default_nettype none
module tb_adc_sequencer_control;
    import asc_pkg::*;
    logic core_clk;
    logic rst_n;
    asc_apb_req_s apb_req;
    asc_apb_rsp_s apb_rsp;
    logic [11:0] core_result;
    logic [9:0] pin_analog_assign;
    asc_analog_s analog;
    logic converter_irq;
    int n_mismatch;
    int tests_run;
    int n_samp;
    int n_conv;
    logic [31:0] rd;
    logic err;
    logic [11:0] r;
    logic j;
    asc_top dut_u (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .apb_req(apb_req),
        .apb_rsp(apb_rsp),
        .core_result(core_result),
        .pin_analog_assign(pin_analog_assign),
        .analog(analog),
        .converter_irq(converter_irq)
    );
    // ==========
    // Clock
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    // Phase lengths in core cycles
    always @(posedge core_clk) begin
        n_samp = n_samp + int'(analog.sample === 1'b1);
        n_conv = n_conv + int'(analog.convert === 1'b1);
    end
    // Hang guard
    initial begin
        repeat (40000) @(posedge core_clk);
        $display("ERROR watchdog expected done seen hang");
        n_mismatch++;
        results();
    end
    // ==========
    // Tasks
    task automatic results();
        $display("TB: checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : results
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            n_mismatch++;
        end
    endtask : chk
    // One APB transfer, held until pready
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        apb_req.psel <= 1'b1;
        apb_req.penable <= 1'b0;
        apb_req.pwrite <= wr;
        apb_req.paddr <= a;
        apb_req.pwdata <= d;
        @(posedge core_clk);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 20);
        chk("pready", 1, apb_rsp.pready);
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask : apb
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 0);
        chk(nm, e, rd);
    endtask : rdchk
    task automatic start(input logic [31:0] c);
        apb(1'b1, 12'h000, c | 32'h80);
        apb(1'b1, 12'h000, c);
    endtask : start
    task automatic settle();
        repeat (2) @(posedge core_clk);
    endtask : settle
    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            apb(1'b0, 12'h000, 0);
            n++;
        end while (rd[6] !== 1'b0 && n < 1000);
        chk("busy clear", 0, rd[6]);
    endtask : wait_idle
    function automatic asc_src_e exp_src(input logic [3:0] c);
        case (c)
            4'h1: return SRC_SUPPLY;
            4'h2: return SRC_SUPPLY_HALF;
            4'h3: return SRC_SUPPLY_QUARTER;
            4'h5: return SRC_AMP_REF;
            4'h6: return SRC_AMP_REF_HALF;
            4'h7: return SRC_AMP_REF_QUARTER;
            4'h8: return SRC_CHARGE_AMP;
            4'h9, 4'ha, 4'hb: return SRC_GROUND;
            default: return SRC_EXTERNAL;
        endcase
    endfunction : exp_src
    // ==========
    // Tests
    initial begin
        rst_n = 1'b0;
        apb_req = '0;
        core_result = 12'h000;
        pin_analog_assign = 10'h000;
        n_mismatch = 0;
        tests_run = 0;
        n_samp = 0;
        n_conv = 0;
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 6; i++) rdchk(12'(4 * i), 0, "reset value");
        apb(1'b1, 12'h018, 32'hff);
        chk("write error", 1, err);
        rdchk(12'h018, 0, "unmapped read");
        apb(1'b1, 12'h004, 32'hffff_ffff);
        rdchk(12'h004, 32'hf7, "source clock");
        apb(1'b1, 12'h008, 32'hff);
        rdchk(12'h008, 32'h0c, "reference");
        apb(1'b1, 12'h000, 32'h41);
        rdchk(12'h000, 32'h01, "busy write");
        $display("TB: register test done");
        apb(1'b1, 12'h000, 32'h21);
        settle();
        chk("power on", 1, analog.power_en);
        for (int s = 0; s < 16; s++) begin
            apb(1'b1, 12'h004, 32'(s) << 4);
            settle();
            chk("source", exp_src(4'(s)), analog.src);
            chk("ext path", exp_src(4'(s)) == SRC_EXTERNAL, analog.ext_connect);
        end
        for (int c = 0; c < 16; c++) begin
            apb(1'b1, 12'h000, 32'h20 | 32'(c));
            settle();
            chk("channel", (c inside {[1:7], 9, 10}) ? 32'h1 << (c - 1) : 0,
                analog.channel_connect);
        end
        for (int v = 0; v < 4; v++) begin
            apb(1'b1, 12'h008, 32'(v) << 2);
            settle();
            chk("ref", v == 0 ? REF_SUPPLY : v == 1 ? REF_PIN : REF_INTERNAL, analog.ref_sel);
            chk("ref pin", v == 1, analog.ref_pin_connect);
        end
        pin_analog_assign <= 10'h2a5;
        settle();
        chk("digital off", 10'h2a5, analog.digital_off);
        chk("pull-high off", 10'h2a5, analog.pullhigh_off);
        $display("TB: decode test done");
        for (int d = 0; d < 8; d++) begin
            r = 12'h5a3 + 12'(d * 273);
            j = d[0];
            core_result <= r;
            apb(1'b1, 12'h004, 32'(d));
            apb(1'b1, 12'h014, {30'h0, j, 1'b0});
            n_samp = 0;
            n_conv = 0;
            start(32'h21 | {27'h0, j, 4'h0});
            rdchk(12'h000, 32'h61 | {27'h0, j, 4'h0}, "busy set");
            wait_idle();
            chk("sample cycles", 4 << d, n_samp);
            chk("convert cycles", 12 << d, n_conv);
            rdchk(12'h00c, j ? r[7:0] : {r[3:0], 4'h0}, "result low");
            rdchk(12'h010, j ? {4'h0, r[11:8]} : r[11:4], "result high");
            rdchk(12'h014, {30'h0, j, 1'b1}, "request flag");
            chk("irq line", j, converter_irq);
            apb(1'b1, 12'h014, 32'h1);
            rdchk(12'h014, 0, "flag cleared");
        end
        apb(1'b1, 12'h000, 32'h00);
        core_result <= 12'h0f0;
        settle();
        chk("power off", 0, analog.power_en);
        start(32'h00);
        rdchk(12'h000, 0, "busy idle");
        rdchk(12'h014, 0, "no request");
        rdchk(12'h010, r[11:4], "held result");
        apb(1'b1, 12'h004, 32'h3);
        apb(1'b1, 12'h000, 32'h20);
        settle();
        start(32'h20);
        rdchk(12'h000, 32'h60, "busy abort");
        apb(1'b1, 12'h000, 32'h00);
        rdchk(12'h000, 0, "aborted");
        rdchk(12'h014, 0, "abort request");
        rdchk(12'h010, r[11:4], "abort result");
        $display("TB: conversion test done");
        results();
    end
endmodule : tb_adc_sequencer_control
`default_nettype wire

/* logic/asc_clk_div.sv */
// Converter clock divider: one tick per converter clock period
`timescale 1ns/1ns
`default_nettype none

module asc_clk_div (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic [2:0] div,
    output logic tick
);
    import asc_pkg::*;

    asc_div_s cur;
    asc_div_s next_cur;
    logic [6:0] limit;

    // ==========================================
    // Divide by 1, 2, 4 ... 128 from the code
    // Tick decoded from the count so a period starts with the first busy cycle
    always_comb begin
        limit = 7'((8'h01 << div) - 8'h01);
        next_cur = cur;
        if (!run) begin
            next_cur.cnt = 7'h00;
            next_cur.tick = 1'b0;
        end else if (cur.cnt >= limit) begin
            next_cur.cnt = 7'h00;
            next_cur.tick = 1'b1;
        end else begin
            next_cur.cnt = cur.cnt + 7'h01;
            next_cur.tick = 1'b0;
        end
    end

    // Last period end of the divider, one tick per period
    always_comb begin
        tick = run && (cur.cnt >= limit);
    end

    // State register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

endmodule : asc_clk_div

`default_nettype wire

/* logic/asc_params.svh */
// Register offsets, field positions, reset values and timing counts of the converter control
`ifndef ASC_PARAMS_SVH
`define ASC_PARAMS_SVH

// ==========================================
// Register byte offsets on the APB
`define ASC_OFF_CTRL 12'h000
`define ASC_OFF_SRC_CLK 12'h004
`define ASC_OFF_REF 12'h008
`define ASC_OFF_RES_LO 12'h00c
`define ASC_OFF_RES_HI 12'h010
`define ASC_OFF_IRQ 12'h014

// ==========================================
// Control register fields
`define ASC_CTRL_START 7
`define ASC_CTRL_BUSY 6
`define ASC_CTRL_EN 5
`define ASC_CTRL_JUSTIFY 4
`define ASC_CTRL_CHAN_LSB 0
// Source and clock register fields
`define ASC_SRC_LSB 4
`define ASC_DIV_LSB 0
// Reference register field
`define ASC_REF_LSB 2
// Interrupt register fields
`define ASC_IRQ_FLAG 0
`define ASC_IRQ_EN 1

// ==========================================
// Reset values
`define ASC_RST_BYTE 8'h00
`define ASC_RST_RESULT 12'h000

// ==========================================
// Conversion length in converter clock periods
`define ASC_SAMPLE_PERIODS 4'h4
`define ASC_CONVERT_PERIODS 4'hc
// Number of external analog input connect lines; channel code 8 selects none
`define ASC_NUM_INPUTS 10

`endif

/* logic/asc_pkg.sv */
// Types of the converter control block
package asc_pkg;

    // ==========================================
    // Conversion sequence states
    typedef enum logic [2:0] {
        CONV_IDLE,
        CONV_SAMPLE,
        CONV_CONVERT,
        CONV_STORE,
        CONV_FINISH
    } asc_conv_e;

    // Signal routed to the converter input
    typedef enum logic [3:0] {
        SRC_EXTERNAL,
        SRC_SUPPLY,
        SRC_SUPPLY_HALF,
        SRC_SUPPLY_QUARTER,
        SRC_AMP_REF,
        SRC_AMP_REF_HALF,
        SRC_AMP_REF_QUARTER,
        SRC_CHARGE_AMP,
        SRC_GROUND
    } asc_src_e;

    // Reference voltage choice
    typedef enum logic [1:0] {
        REF_SUPPLY,
        REF_PIN,
        REF_INTERNAL
    } asc_ref_e;

    // ==========================================
    // APB request and answer
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } asc_apb_req_s;

    typedef struct packed {
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } asc_apb_rsp_s;

    // Controls driven to the analog core and pins
    typedef struct packed {
        logic power_en;
        logic sample;
        logic convert;
        logic conv_tick;
        asc_src_e src;
        logic ext_connect;
        logic [9:0] channel_connect;
        asc_ref_e ref_sel;
        logic ref_pin_connect;
        logic [9:0] digital_off;
        logic [9:0] pullhigh_off;
    } asc_analog_s;

    // Divider state
    typedef struct packed {
        logic [6:0] cnt;
        logic tick;
    } asc_div_s;

    // Whole state of the top module
    typedef struct packed {
        asc_conv_e conv;
        logic [3:0] periods;
        logic start;
        logic busy;
        logic en;
        logic justify;
        logic [3:0] chan;
        logic [3:0] src_code;
        logic [2:0] div;
        logic [1:0] ref_code;
        logic [11:0] result;
        logic irq_flag;
        logic irq_en;
        logic irq;
        asc_apb_rsp_s rsp;
        asc_analog_s ana;
    } asc_state_s;

endpackage : asc_pkg

/* logic/asc_result_fmt.sv */
// Places the 12-bit result into the high and low result bytes
`timescale 1ns/1ns
`default_nettype none

module asc_result_fmt (
    input wire logic [11:0] result,
    input wire logic justify,
    output logic [7:0] low_byte,
    output logic [7:0] high_byte
);

    // ==========================================
    // Left or right aligned layout, unused bits zero
    always_comb begin
        if (justify) begin
            high_byte = {4'h0, result[11:8]};
            low_byte = result[7:0];
        end else begin
            high_byte = result[11:4];
            low_byte = {result[3:0], 4'h0};
        end
    end

endmodule : asc_result_fmt

`default_nettype wire

/* logic/asc_top.sv */
// Converter control: APB registers, start and busy sequencing, input and reference routing
//
// Chosen here: the register addresses and the APB slave port.
`timescale 1ns/1ns
`default_nettype none

`include "asc_params.svh"

module asc_top (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire asc_pkg::asc_apb_req_s apb_req,
    output asc_pkg::asc_apb_rsp_s apb_rsp,
    input wire logic [11:0] core_result,
    input wire logic [9:0] pin_analog_assign,
    output asc_pkg::asc_analog_s analog,
    output logic converter_irq
);
    import asc_pkg::*;

    asc_state_s cur;
    asc_state_s next_cur;
    logic tick;
    logic [7:0] res_lo;
    logic [7:0] res_hi;
    logic access;
    logic wr_done;
    logic rd_done;
    logic mapped;
    logic start_fall;
    logic [7:0] rd_byte;

    // ==========================================
    // Converter clock divider, runs only during a conversion
    asc_clk_div u_div (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .run(cur.busy),
        .div(cur.div),
        .tick(tick)
    );

    // Result byte layout for reads
    asc_result_fmt u_fmt (
        .result(cur.result),
        .justify(cur.justify),
        .low_byte(res_lo),
        .high_byte(res_hi)
    );

    // ==========================================
    // Next state of the whole block
    always_comb begin
        next_cur = cur;

        // APB access phase: one wait cycle, completes when pready is set
        access = apb_req.psel && apb_req.penable;
        wr_done = access && cur.rsp.pready && apb_req.pwrite;
        rd_done = access && cur.rsp.pready && !apb_req.pwrite;
        mapped = (apb_req.paddr == `ASC_OFF_CTRL) || (apb_req.paddr == `ASC_OFF_SRC_CLK)
            || (apb_req.paddr == `ASC_OFF_REF) || (apb_req.paddr == `ASC_OFF_RES_LO)
            || (apb_req.paddr == `ASC_OFF_RES_HI) || (apb_req.paddr == `ASC_OFF_IRQ);
        start_fall = 1'b0;

        // ==========================================
        // Read data mux
        // zero unused bits
        unique case (apb_req.paddr)
            `ASC_OFF_CTRL: begin
                rd_byte = {cur.start, cur.busy, cur.en, cur.justify, cur.chan};
            end
            `ASC_OFF_SRC_CLK: begin
                rd_byte = {cur.src_code, 1'b0, cur.div};
            end
            `ASC_OFF_REF: begin
                rd_byte = {4'h0, cur.ref_code, 2'b00};
            end
            `ASC_OFF_RES_LO: begin
                rd_byte = res_lo;
            end
            `ASC_OFF_RES_HI: begin
                rd_byte = res_hi;
            end
            `ASC_OFF_IRQ: begin
                rd_byte = {6'h00, cur.irq_en, cur.irq_flag};
            end
            default: begin
                rd_byte = 8'h00;
            end
        endcase

        // Answer: pready one cycle after the access phase starts
        next_cur.rsp.pready = access && !cur.rsp.pready;
        next_cur.rsp.pslverr = access && !cur.rsp.pready && !mapped;
        if (access && !cur.rsp.pready && !apb_req.pwrite) begin
            next_cur.rsp.prdata = {24'h000000, rd_byte};
        end else if (rd_done) begin
            next_cur.rsp.prdata = 32'h00000000;
        end

        // ==========================================
        // Register writes
        if (wr_done) begin
            unique case (apb_req.paddr)
                `ASC_OFF_CTRL: begin
                    start_fall = cur.start && !apb_req.pwdata[`ASC_CTRL_START];
                    next_cur.start = apb_req.pwdata[`ASC_CTRL_START];
                    next_cur.en = apb_req.pwdata[`ASC_CTRL_EN];
                    next_cur.justify = apb_req.pwdata[`ASC_CTRL_JUSTIFY];
                    next_cur.chan = apb_req.pwdata[`ASC_CTRL_CHAN_LSB +: 4];
                end
                `ASC_OFF_SRC_CLK: begin
                    next_cur.src_code = apb_req.pwdata[`ASC_SRC_LSB +: 4];
                    next_cur.div = apb_req.pwdata[`ASC_DIV_LSB +: 3];
                end
                `ASC_OFF_REF: begin
                    next_cur.ref_code = apb_req.pwdata[`ASC_REF_LSB +: 2];
                end
                `ASC_OFF_IRQ: begin
                    next_cur.irq_en = apb_req.pwdata[`ASC_IRQ_EN];
                    // Write one clears the request
                    if (apb_req.pwdata[`ASC_IRQ_FLAG]) begin
                        next_cur.irq_flag = 1'b0;
                    end
                end
                default: begin
                    next_cur.irq_en = cur.irq_en;
                end
            endcase
        end

        // ==========================================
        // Conversion sequence
        unique case (cur.conv)
            CONV_IDLE: begin
                if (start_fall && cur.en) begin
                    next_cur.conv = CONV_SAMPLE;
                    next_cur.busy = 1'b1;
                    next_cur.periods = 4'h0;
                end
            end
            CONV_SAMPLE: begin
                if (tick) begin
                    if (cur.periods == `ASC_SAMPLE_PERIODS - 4'h1) begin
                        next_cur.conv = CONV_CONVERT;
                        next_cur.periods = 4'h0;
                    end else begin
                        next_cur.periods = cur.periods + 4'h1;
                    end
                end
            end
            CONV_CONVERT: begin
                if (tick) begin
                    if (cur.periods == `ASC_CONVERT_PERIODS - 4'h1) begin
                        next_cur.conv = CONV_STORE;
                        next_cur.periods = 4'h0;
                    end else begin
                        next_cur.periods = cur.periods + 4'h1;
                    end
                end
            end
            CONV_STORE: begin
                next_cur.result = core_result;
                next_cur.conv = CONV_FINISH;
            end
            CONV_FINISH: begin
                next_cur.busy = 1'b0;
                next_cur.irq_flag = 1'b1;
                next_cur.conv = CONV_IDLE;
            end
            default: begin
                next_cur.conv = CONV_IDLE;
            end
        endcase

        if (!cur.en && cur.conv != CONV_IDLE) begin
            next_cur.conv = CONV_IDLE;
            next_cur.busy = 1'b0;
            next_cur.periods = 4'h0;
            next_cur.result = cur.result;
        end

        next_cur.irq = next_cur.irq_flag && next_cur.irq_en;

        // ==========================================
        // Analog core controls
        // power follows enable
        next_cur.ana.power_en = next_cur.en;
        next_cur.ana.sample = next_cur.conv == CONV_SAMPLE;
        next_cur.ana.convert = next_cur.conv == CONV_CONVERT;
        next_cur.ana.conv_tick = tick;

        unique case (next_cur.src_code)
            4'h1: next_cur.ana.src = SRC_SUPPLY;
            4'h2: next_cur.ana.src = SRC_SUPPLY_HALF;
            4'h3: next_cur.ana.src = SRC_SUPPLY_QUARTER;
            4'h5: next_cur.ana.src = SRC_AMP_REF;
            4'h6: next_cur.ana.src = SRC_AMP_REF_HALF;
            4'h7: next_cur.ana.src = SRC_AMP_REF_QUARTER;
            4'h8: next_cur.ana.src = SRC_CHARGE_AMP;
            4'h9, 4'ha, 4'hb: next_cur.ana.src = SRC_GROUND;
            default: next_cur.ana.src = SRC_EXTERNAL;
        endcase

        next_cur.ana.ext_connect = next_cur.ana.src == SRC_EXTERNAL;

        // channel decode, reserved and floating codes connect none
        for (int i = 0; i < `ASC_NUM_INPUTS; i++) begin
            next_cur.ana.channel_connect[i] = next_cur.ana.ext_connect
                && (next_cur.chan == 4'(i + 1)) && (i != 7);
        end

        unique case (next_cur.ref_code)
            2'b00: next_cur.ana.ref_sel = REF_SUPPLY;
            2'b01: next_cur.ana.ref_sel = REF_PIN;
            default: next_cur.ana.ref_sel = REF_INTERNAL;
        endcase
        next_cur.ana.ref_pin_connect = next_cur.ana.ref_sel == REF_PIN;

        // analog pins drop digital function and pull-high
        next_cur.ana.digital_off = pin_analog_assign;
        next_cur.ana.pullhigh_off = pin_analog_assign;
    end

    // ==========================================
    // State register, everything zero at reset
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    // Outputs straight from the state register
    assign apb_rsp = cur.rsp;
    assign analog = cur.ana;
    assign converter_irq = cur.irq;

endmodule : asc_top

`default_nettype wire
